// File: shared/srw_pkg.sv
package srw_pkg;

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    localparam longint SRW_CLK_HZ      = 64'h0000_0000_05F5_E100; // 100 MHz
    localparam longint SRW_MS_PER_S    = 64'h0000_0000_0000_03E8; // 1000
    localparam longint SRW_NS_PER_S    = 64'h0000_0000_3B9A_CA00; // 1e9

    // ------------------------------------------------------------------
    // Documented times
    // ------------------------------------------------------------------
    localparam longint SRW_RESET_HOLD_MS   = 64'h0000_0000_0000_008C; // 140 ms min
    localparam longint SRW_WDOG_TIMEOUT_MS = 64'h0000_0000_0000_0640; // 1.6 s nominal
    localparam longint SRW_KICK_MIN_NS     = 64'h0000_0000_0000_0032; // 50 ns
    localparam longint SRW_MR_DEBOUNCE_NS  = 64'h0000_0000_0000_03E8; // 1 us min pulse

    // Idle drive splits the timeout into eighths: low 7, high 1
    localparam longint SRW_IDLE_LOW_NUM    = 64'h0000_0000_0000_0007;
    localparam longint SRW_IDLE_DEN        = 64'h0000_0000_0000_0008;

    // ------------------------------------------------------------------
    // Time to cycles
    // ------------------------------------------------------------------
    function automatic longint srw_cycles_min(longint t, longint unit_per_s, longint hz);
        longint c;
        c = (t * hz + unit_per_s - 64'h1) / unit_per_s;
        return (c < 64'h1) ? 64'h1 : c;
    endfunction : srw_cycles_min

    function automatic longint srw_cycles_max(longint t, longint unit_per_s, longint hz);
        longint c;
        c = (t * hz) / unit_per_s;
        return (c < 64'h1) ? 64'h1 : c;
    endfunction : srw_cycles_max

endpackage : srw_pkg

// File: src/srw_debounce.sv
module srw_debounce
    import srw_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = 32'h64
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic level_i,
    output logic      clean_o
);

    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(STABLE_CYCLES - 1);

    logic [CNT_W-1:0] cnt;

    // ------------------------------------------------------------------
    // Stability counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt <= '0;
        else if (level_i == clean_o || cnt == LAST)
            cnt <= '0;
        else
            cnt <= cnt + CNT_W'(1);
    end

    // Released level is high, so a floating input never resets
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            clean_o <= 1'b1;
        else if (level_i != clean_o && cnt == LAST)
            clean_o <= level_i;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    debounce_settle_a: assert property ($changed(clean_o) |-> $past(cnt) == LAST)
        else $error("debounced level changed before input was stable");

endmodule : srw_debounce

// File: src/srw_supervisor.sv
module srw_supervisor
    import srw_pkg::*;
#(
    parameter longint      TICK_HZ          = SRW_CLK_HZ,
    parameter int unsigned HOLD_CYCLES      =
        32'(srw_cycles_min(SRW_RESET_HOLD_MS, SRW_MS_PER_S, TICK_HZ)),
    parameter int unsigned WDOG_CYCLES      =
        32'(srw_cycles_max(SRW_WDOG_TIMEOUT_MS, SRW_MS_PER_S, TICK_HZ)),
    parameter int unsigned DEBOUNCE_CYCLES  =
        32'(srw_cycles_min(SRW_MR_DEBOUNCE_NS, SRW_NS_PER_S, TICK_HZ)),
    parameter bit          RST_ACTIVE_HIGH  = 1'b0,
    parameter bit          RST_OPEN_DRAIN   = 1'b0,
    parameter bit          HAS_WATCHDOG     = 1'b1,
    parameter bit          HAS_MANUAL_RESET = 1'b1
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic supply_low_i,
    input  wire logic manual_reset_n_in_i,
    output logic      manual_reset_pull_oe_o,
    input  wire logic watchdog_kick_in_i,
    output logic      watchdog_kick_out_o,
    output logic      watchdog_kick_oe_o,
    output logic      reset_out_o,
    output logic      reset_oe_o
);

    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam int WD_W   = $clog2(WDOG_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);
    localparam logic [WD_W-1:0]   WD_LAST   = WD_W'(WDOG_CYCLES - 1);
    localparam logic [WD_W-1:0]   WD_LOW    =
        WD_W'((longint'(WDOG_CYCLES) * SRW_IDLE_LOW_NUM) / SRW_IDLE_DEN);
    localparam logic ASSERT_LVL = RST_ACTIVE_HIGH;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] meta;
    logic [2:0] sync;
    logic       supply_s;
    logic       mr_s;
    logic       kick_s;
    logic       kick_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            // Kick starts at its idle low level, so no false edge after reset
            meta <= 3'h4;
            sync <= 3'h4;
        end
        else
        begin
            meta <= {manual_reset_n_in_i, watchdog_kick_in_i, supply_low_i};
            sync <= meta;
        end
    end

    assign supply_s = sync[0];
    assign kick_s   = sync[1];
    assign mr_s     = HAS_MANUAL_RESET ? sync[2] : 1'b1;

    // Weak pull-up keeps an open manual input released
    assign manual_reset_pull_oe_o = HAS_MANUAL_RESET;

    // ------------------------------------------------------------------
    // Manual reset debounce
    // ------------------------------------------------------------------
    logic mr_clean;

    srw_debounce #(
        .STABLE_CYCLES (DEBOUNCE_CYCLES)
    ) u_mr_debounce (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .level_i    (mr_s),
        .clean_o    (mr_clean)
    );

    // ------------------------------------------------------------------
    // Reset causes and hold timer
    // ------------------------------------------------------------------
    logic [HOLD_W-1:0] hold_cnt;
    logic [WD_W-1:0]   wd_cnt;
    logic              rst_base;
    logic              wd_expire;
    logic              cause;
    logic              rst_act;
    logic              reset_q;

    assign rst_base  = supply_s || !mr_clean || hold_cnt != '0;
    assign wd_expire = HAS_WATCHDOG && !rst_base && wd_cnt == WD_LAST;
    assign rst_act   = rst_base || wd_expire;
    assign cause     = supply_s || !mr_clean || wd_expire;

    // Reloads while any cause stands, then runs down once
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            hold_cnt <= HOLD_LOAD;
        else if (cause)
            hold_cnt <= HOLD_LOAD;
        else if (hold_cnt != '0)
            hold_cnt <= hold_cnt - HOLD_W'(1);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            reset_q <= 1'b1;
        else
            reset_q <= rst_act;
    end

    // Polarity and drive style fixed at build time
    assign reset_out_o = RST_OPEN_DRAIN ? 1'b0 : (reset_q ~^ ASSERT_LVL);
    assign reset_oe_o  = RST_OPEN_DRAIN ? reset_q : 1'b1;

    // ------------------------------------------------------------------
    // Watchdog timer
    // ------------------------------------------------------------------
    logic kick_edge;

    // Kick is sampled every 10 ns, so a 50 ns pulse spans several samples
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            kick_q <= 1'b0;
        else
            kick_q <= kick_s;
    end

    assign kick_edge = kick_s ^ kick_q;

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wd_cnt <= '0;
        else if (!HAS_WATCHDOG || rst_act || kick_edge)
            wd_cnt <= '0;
        else if (wd_cnt != WD_LAST)
            wd_cnt <= wd_cnt + WD_W'(1);
    end

    // Weak idle driver: low then high in last eighth of the timeout
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            watchdog_kick_out_o <= 1'b0;
        else
            watchdog_kick_out_o <= (wd_cnt >= WD_LOW);
    end

    assign watchdog_kick_oe_o = HAS_WATCHDOG;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence cause_ends_s;
        $fell(cause);
    endsequence

    sequence wd_runs_out_s;
        HAS_WATCHDOG && !rst_base && wd_cnt == WD_LAST;
    endsequence

    sequence held_full_s;
        hold_cnt == HOLD_LOAD && reset_q;
    endsequence

    // Kick pulse of five samples, the 50 ns minimum
    sequence short_pulse_s;
        $rose(kick_s) ##1 kick_s [*4] ##1 !kick_s;
    endsequence

    supply_asserts_a: assert property (
        supply_s |=> (RST_OPEN_DRAIN ? reset_oe_o : reset_out_o == ASSERT_LVL))
        else $error("reset output not asserted during supply low");

    hold_reload_a: assert property (cause_ends_s |-> hold_cnt == HOLD_LOAD)
        else $error("hold timer not full when cause cleared");

    release_at_end_a: assert property (
        $fell(rst_act) |-> $past(hold_cnt) == HOLD_W'(1) && !$past(cause))
        else $error("reset released before hold timer ran out");

    manual_asserts_a: assert property (!mr_clean |=> reset_q)
        else $error("reset not asserted while manual input low");

    wd_expiry_a: assert property (wd_runs_out_s |=> held_full_s)
        else $error("watchdog expiry did not start a full reset hold");

    kick_clears_a: assert property (kick_edge |=> wd_cnt == '0)
        else $error("watchdog timer not cleared by kick edge");

    short_kick_a: assert property (
        short_pulse_s |=> wd_cnt == '0)
        else $error("short kick pulse failed to clear timer");

    wd_frozen_a: assert property (rst_act |=> wd_cnt == '0)
        else $error("watchdog timer counted during reset");

    wd_starts_a: assert property (
        $fell(rst_act) && HAS_WATCHDOG && !kick_edge |=> wd_cnt == WD_W'(1))
        else $error("watchdog timer did not start when reset released");

    idle_drive_a: assert property (
        $rose(watchdog_kick_out_o) |-> $past(wd_cnt) == WD_LOW)
        else $error("idle drive rose at wrong point of timeout");

    manual_clears_a: assert property (!mr_clean |=> wd_cnt == '0)
        else $error("manual reset did not clear watchdog timer");

endmodule : srw_supervisor

// File: tb/srw_host_model.sv
module srw_host_model #(
    parameter int GAP = 150
) (
    input  wire logic       clk_i,
    input  wire logic [1:0] mode_i,
    output logic            drv_oe_o,
    output logic            drv_val_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt;

    initial
    begin
        cnt       = 0;
        drv_oe_o  = 1'b0;
        drv_val_o = 1'b0;
    end

    // Mode 0 releases, 1 holds low, 2 pulses, 3 toggles level
    always @(negedge clk_i)
    begin
        cnt = (cnt == GAP - 1) ? 0 : cnt + 1;
        drv_oe_o <= (mode_i != 2'h0);
        case (mode_i)
            2'h2: drv_val_o <= (cnt < 5); // Low most of the time, 50 ns pulse
            2'h3: drv_val_o <= (cnt == 0) ? ~drv_val_o : drv_val_o; // Set, reset apart
            default: drv_val_o <= 1'b0;
        endcase
    end
endmodule : srw_host_model

// File: tb/srw_supervisor_bench.sv
module srw_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import srw_pkg::*;

    localparam int   HOLD  = 50;
    localparam int   WDOG  = 400;
    localparam logic ASSRT = 1'b0;

    logic       core_clk_i = 1'b0;
    logic       arst_n_i   = 1'b0;
    logic       supply_low = 1'b0;
    logic       mr_low     = 1'b0;
    logic [1:0] mode       = 2'h2;
    logic       mr_pull_oe, kick_out, kick_oe, reset_out, reset_oe, host_oe, host_val;
    logic       hi_out, hi_oe, od_out, od_oe;
    wire        mr_pin, kick_pin;
    int         n_fail      = 0;
    int         check_count = 0;
    int         n;
    logic       ok, hi;

    always #5 core_clk_i = ~core_clk_i;

    assign mr_pin   = mr_low ? 1'b0 : (mr_pull_oe ? 1'b1 : core_clk_i);
    assign kick_pin = host_oe ? host_val : (kick_oe ? kick_out : core_clk_i);

    srw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .DEBOUNCE_CYCLES(8)) dut (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .supply_low_i(supply_low),
        .manual_reset_n_in_i(mr_pin), .manual_reset_pull_oe_o(mr_pull_oe),
        .watchdog_kick_in_i(kick_pin), .watchdog_kick_out_o(kick_out),
        .watchdog_kick_oe_o(kick_oe), .reset_out_o(reset_out), .reset_oe_o(reset_oe));

    // Output variants share the same pins
    srw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .DEBOUNCE_CYCLES(8),
        .RST_ACTIVE_HIGH(1'b1)) dut_hi (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .supply_low_i(supply_low),
        .manual_reset_n_in_i(mr_pin), .manual_reset_pull_oe_o(),
        .watchdog_kick_in_i(kick_pin), .watchdog_kick_out_o(),
        .watchdog_kick_oe_o(), .reset_out_o(hi_out), .reset_oe_o(hi_oe));

    srw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .DEBOUNCE_CYCLES(8),
        .RST_OPEN_DRAIN(1'b1)) dut_od (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .supply_low_i(supply_low),
        .manual_reset_n_in_i(mr_pin), .manual_reset_pull_oe_o(),
        .watchdog_kick_in_i(kick_pin), .watchdog_kick_out_o(),
        .watchdog_kick_oe_o(), .reset_out_o(od_out), .reset_oe_o(od_oe));

    srw_host_model host (.clk_i(core_clk_i), .mode_i(mode), .drv_oe_o(host_oe),
        .drv_val_o(host_val));

    task automatic check(input string name, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
        end
    endtask : check

    // Drive style of all variants, output level of the active-high and open-drain ones
    task automatic check_variants(input logic asserted);
        check("push_pull_oe", reset_oe, 1'b1);
        check("active_high_level", hi_out, asserted);
        check("active_high_oe", hi_oe, 1'b1);
        check("open_drain_oe", od_oe, asserted);
        check("open_drain_level", od_out, 1'b0);
    endtask : check_variants

    // Cycles until the reset output reaches a level, capped
    task automatic wait_lvl(input logic lvl, input int max, output int cyc);
        cyc = 0;
        while (reset_out !== lvl && cyc < max)
        begin
            @(negedge core_clk_i);
            cyc++;
        end
    endtask : wait_lvl

    // Reset must stay released for a span; also notes idle drive high
    task automatic quiet(input int span, output logic q, output logic h);
        q = 1'b1;
        h = 1'b0;
        repeat (span)
        begin
            @(negedge core_clk_i);
            if (reset_out !== ~ASSRT) q = 1'b0;
            if (kick_out === 1'b1) h = 1'b1;
        end
    endtask : quiet

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic t_power_on;
        check("por_asserted", reset_out, ASSRT);
        check_variants(1'b1);
        check("pull_enabled", mr_pull_oe, 1'b1);
        wait_lvl(~ASSRT, HOLD + 20, n);
        check("por_hold", (n >= HOLD && n < HOLD + 20), 1'b1);
        check_variants(1'b0);
    endtask : t_power_on

    // Mid-run power cycle restarts the full hold
    task automatic t_power_cycle;
        arst_n_i = 1'b0;
        @(negedge core_clk_i);
        check("rst_forces_assert", reset_out, ASSRT);
        check_variants(1'b1);
        repeat (3) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        wait_lvl(~ASSRT, HOLD + 20, n);
        check("rerun_hold", (n >= HOLD && n < HOLD + 20), 1'b1);
    endtask : t_power_cycle

    task automatic t_supply;
        supply_low = 1'b1;
        wait_lvl(ASSRT, 6, n);
        check("supply_assert", n < 6, 1'b1);
        repeat (100) @(negedge core_clk_i);
        check("supply_stays", reset_out, ASSRT);
        check_variants(1'b1);
        supply_low = 1'b0;
        wait_lvl(~ASSRT, HOLD + 20, n);
        check("supply_hold", (n >= HOLD && n < HOLD + 20), 1'b1);
        check_variants(1'b0);
    endtask : t_supply

    task automatic t_manual;
        mr_low = 1'b1;
        repeat (3) @(negedge core_clk_i);
        mr_low = 1'b0;
        quiet(40, ok, hi);
        check("glitch_ignored", ok, 1'b1);
        mr_low = 1'b1;
        wait_lvl(ASSRT, 20, n);
        check("manual_assert", n < 20, 1'b1);
        repeat (200) @(negedge core_clk_i);
        check("manual_stays", reset_out, ASSRT);
        mr_low = 1'b0;
        wait_lvl(~ASSRT, HOLD + 30, n);
        check("manual_hold", (n >= HOLD && n < HOLD + 30), 1'b1);
    endtask : t_manual

    task automatic t_serviced;
        for (int m = 0; m < 3; m++)
        begin
            mode = (m == 2) ? 2'h0 : 2'(m + 2);
            quiet(3 * WDOG, ok, hi);
            check("kick_keeps_alive", ok, 1'b1);
        end
        check("idle_drive_high", hi, 1'b1);
    endtask : t_serviced

    task automatic t_expire;
        mode = 2'h1;
        wait_lvl(ASSRT, WDOG + 20, n);
        check("wdog_fires", n < WDOG + 20, 1'b1);
        wait_lvl(~ASSRT, HOLD + 20, n);
        check("wdog_hold", (n >= HOLD && n < HOLD + 20), 1'b1);
        wait_lvl(ASSRT, WDOG + 20, n);
        check("timer_from_zero", (n >= WDOG - 5 && n < WDOG + 20), 1'b1);
        wait_lvl(~ASSRT, HOLD + 20, n);
        repeat (WDOG / 2) @(negedge core_clk_i);
        mr_low = 1'b1;
        repeat (30) @(negedge core_clk_i);
        mr_low = 1'b0;
        wait_lvl(~ASSRT, HOLD + 30, n);
        wait_lvl(ASSRT, WDOG + 20, n);
        check("manual_clears_timer", (n >= WDOG - 5 && n < WDOG + 20), 1'b1);
        mode = 2'h2;
        wait_lvl(~ASSRT, HOLD + 20, n);
    endtask : t_expire

    initial
    begin
        repeat (20) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        @(negedge core_clk_i);
        t_power_on();
        t_supply();
        t_manual();
        t_serviced();
        t_expire();
        t_power_cycle();
        end_of_test();
    end

    initial
    begin
        repeat (30000) @(posedge core_clk_i);
        n_fail++;
        end_of_test();
    end
endmodule : srw_supervisor_bench
